// file: hdl/spi_port_cfg.svh
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define CONTROL_REG_ADDR    8'hbc
`define STATUS_REG_ADDR     8'hbd
`define SHIFT_DATA_REG_ADDR 8'hbe

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CTRL_PORT_ENABLE_BIT 7
`define CTRL_CONTROLLER_BIT  6
`define CTRL_IDLE_LEVEL_BIT  5
`define CTRL_SAMPLE_EDGE_BIT 4
`define CTRL_BIT_ORDER_BIT   2
`define STAT_DONE_BIT        7
`define STAT_COLLISION_BIT   6
`define STAT_OVERRUN_BIT     4
`define STAT_FULL_BIT        3
`define STAT_BUSY_BIT        2

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define CONTROL_REG_RST    8'h00
`define SHIFT_DATA_REG_RST 8'h00

// ------------------------------------------------------------
// Timing counts: clock cycles per half serial period, minus one, and the index of the last of the 16 clock edges
// ------------------------------------------------------------
`define HALF_RELOAD_DIV2  3'h0
`define HALF_RELOAD_DIV4  3'h1
`define HALF_RELOAD_DIV8  3'h3
`define HALF_RELOAD_DIV16 3'h7
`define LAST_EDGE_INDEX   4'hf

`endif

// file: hdl/spi_port_pkg.sv
// Types shared by the serial port and its users
package spi_port_pkg;

  typedef struct packed {
    logic       port_enable;
    logic       controller_select;
    logic       clock_idle_level;
    logic       sample_edge_select;
    logic       bit_order_select;
    logic [1:0] clock_rate_field;
  } ctrl_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_type;

  typedef struct packed {
    logic data;
    logic drive_n;
  } pin_out_type;

  typedef enum logic {
    XFER_IDLE = 1'b0,
    XFER_RUN  = 1'b1
  } xfer_state_type;

endpackage

// file: hdl/spi_master_slave_port.sv
// Byte-wide full-duplex serial port, master or slave, with its register file
`include "spi_port_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module spi_master_slave_port (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire spi_port_pkg::reg_req_type req_i,
  output logic [7:0]                    rdata_o,
  output logic                          irq_o,
  input  wire logic                     sck_i,
  output spi_port_pkg::pin_out_type     sck_o,
  input  wire logic                     mosi_i,
  output spi_port_pkg::pin_out_type     mosi_o,
  input  wire logic                     miso_i,
  output spi_port_pkg::pin_out_type     miso_o
);
  import spi_port_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic out_bit(input logic [7:0] sr, input logic lsb_first);
    out_bit = lsb_first ? sr[0] : sr[7];
  endfunction

  // Bits leave at one end and enter at the other, so the register always
  // presents the next bit to send while it gathers the received byte
  function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic lsb_first,
                                          input logic din);
    shift_in = lsb_first ? {din, sr[7:1]} : {sr[6:0], din};
  endfunction

  function automatic logic [2:0] half_reload(input logic [1:0] rate);
    unique case (rate)
      2'b00: half_reload = `HALF_RELOAD_DIV2;
      2'b01: half_reload = `HALF_RELOAD_DIV4;
      2'b10: half_reload = `HALF_RELOAD_DIV8;
      2'b11: half_reload = `HALF_RELOAD_DIV16;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------
  logic [2:0] sck_sync_q;
  logic [2:0] sck_sync_d;
  logic [2:0] mosi_sync_q;
  logic [2:0] mosi_sync_d;
  logic       sck_f_q;
  logic       sck_f_d;
  logic       mosi_f_q;
  logic       mosi_f_d;

  // A level is accepted only when the second and third stages agree
  always_comb begin
    sck_sync_d  = {sck_sync_q[1:0], sck_i};
    mosi_sync_d = {mosi_sync_q[1:0], mosi_i};
    sck_f_d     = (sck_sync_q[1] == sck_sync_q[2]) ? sck_sync_q[2] : sck_f_q;
    mosi_f_d    = (mosi_sync_q[1] == mosi_sync_q[2]) ? mosi_sync_q[2] : mosi_f_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sck_sync_q  <= 3'h0;
      mosi_sync_q <= 3'h0;
      sck_f_q     <= 1'b0;
      mosi_f_q    <= 1'b0;
    end else begin
      sck_sync_q  <= sck_sync_d;
      mosi_sync_q <= mosi_sync_d;
      sck_f_q     <= sck_f_d;
      mosi_f_q    <= mosi_f_d;
    end
  end

  // ------------------------------------------------------------
  // Port core state
  // ------------------------------------------------------------
  ctrl_type       ctrl_q;
  ctrl_type       ctrl_d;
  xfer_state_type state_q;
  xfer_state_type state_d;
  logic [7:0]     shift_q;
  logic [7:0]     shift_d;
  logic [7:0]     rx_buf_q;
  logic [7:0]     rx_buf_d;
  logic [7:0]     rdata_q;
  logic [7:0]     rdata_d;
  logic [3:0]     edge_q;
  logic [3:0]     edge_d;
  logic [2:0]     div_q;
  logic [2:0]     div_d;
  logic           phase_q;
  logic           phase_d;
  logic           dout_q;
  logic           dout_d;
  logic           sck_prev_q;
  logic           sck_prev_d;
  logic           done_q;
  logic           done_d;
  logic           write_collision_flag_q;
  logic           write_collision_flag_d;
  logic           ovf_q;
  logic           ovf_d;
  logic           full_q;
  logic           full_d;

  logic           wr_ctrl;
  logic           wr_stat;
  logic           wr_data;
  logic           rd_data;
  logic           busy;
  logic           master;
  logic           tick;
  logic           leading;
  logic           sample_edge;
  logic           din;

  always_comb begin
    ctrl_d      = ctrl_q;
    state_d     = state_q;
    shift_d     = shift_q;
    rx_buf_d    = rx_buf_q;
    edge_d      = edge_q;
    div_d       = div_q;
    phase_d     = phase_q;
    dout_d      = dout_q;
    done_d      = done_q;
    write_collision_flag_d      = write_collision_flag_q;
    ovf_d       = ovf_q;
    full_d      = full_q;
    rdata_d     = 8'h00;
    sck_prev_d  = sck_f_q;
    wr_ctrl     = req_i.we && (req_i.addr == `CONTROL_REG_ADDR);
    wr_stat     = req_i.we && (req_i.addr == `STATUS_REG_ADDR);
    wr_data     = req_i.we && (req_i.addr == `SHIFT_DATA_REG_ADDR);
    rd_data     = req_i.re && (req_i.addr == `SHIFT_DATA_REG_ADDR);
    busy        = (state_q == XFER_RUN);
    master      = ctrl_q.controller_select;
    // data direction
    // MISO answers our own SCK, so it is timed by this clock; synchronising
    // it would cost more than a half period at the fast rates
    din         = master ? miso_i : mosi_f_q;
    tick        = 1'b0;
    leading     = 1'b0;
    sample_edge = 1'b0;

    // Software clears by writing zero; hardware sets below win
    // zero write clears
    if (wr_stat) begin
      if (!req_i.wdata[`STAT_DONE_BIT])      done_d = 1'b0;
      if (!req_i.wdata[`STAT_COLLISION_BIT]) write_collision_flag_d = 1'b0;
      if (!req_i.wdata[`STAT_OVERRUN_BIT])   ovf_d  = 1'b0;
      if (!req_i.wdata[`STAT_FULL_BIT])      full_d = 1'b0;
    end
    if (rd_data) begin
      full_d = 1'b0;
      ovf_d  = 1'b0;
    end

    if (wr_ctrl) begin
      ctrl_d.port_enable        = req_i.wdata[`CTRL_PORT_ENABLE_BIT];
      ctrl_d.controller_select  = req_i.wdata[`CTRL_CONTROLLER_BIT];
      ctrl_d.clock_idle_level   = req_i.wdata[`CTRL_IDLE_LEVEL_BIT];
      ctrl_d.sample_edge_select = req_i.wdata[`CTRL_SAMPLE_EDGE_BIT];
      ctrl_d.bit_order_select   = req_i.wdata[`CTRL_BIT_ORDER_BIT];
      ctrl_d.clock_rate_field   = req_i.wdata[1:0];
    end

    // Transfer edge source: own divider as master, filtered pin as slave
    if (ctrl_q.port_enable && busy && master) begin
      if (div_q == 3'h0) begin
        div_d   = half_reload(ctrl_q.clock_rate_field);
        phase_d = !phase_q;
        tick    = 1'b1;
        leading = !phase_q;
      end else begin
        div_d = div_q - 3'h1;
      end
    end else if (ctrl_q.port_enable && !master && (sck_f_q != sck_prev_q)) begin
      tick    = 1'b1;
      leading = (sck_prev_q == ctrl_q.clock_idle_level);
    end

    sample_edge = tick && (leading != ctrl_q.sample_edge_select);

    if (!ctrl_q.port_enable) begin
      state_d = XFER_IDLE;
      edge_d  = 4'h0;
      phase_d = 1'b0;
    end else if (tick) begin
      if (!busy) begin
        // A slave transfer starts with the first clock edge it sees
        state_d = XFER_RUN;
      end
      edge_d = edge_q + 4'h1;
      if (sample_edge) begin
        shift_d = shift_in(shift_q, ctrl_q.bit_order_select, din);
        // Eighth sample: the byte is complete
        if (edge_q[3:1] == 3'h7) begin
          done_d = 1'b1;
          if (full_q) begin
            ovf_d = 1'b1;
          end
          if (master || !full_q) begin
            rx_buf_d = shift_in(shift_q, ctrl_q.bit_order_select, din);
          end
          full_d = 1'b1;
        end
      end else begin
        // next bit goes out on shift edge
        dout_d = out_bit(shift_q, ctrl_q.bit_order_select);
      end
      if (edge_q == `LAST_EDGE_INDEX) begin
        state_d = XFER_IDLE;
        edge_d  = 4'h0;
      end
    end

    // Between transfers the output pin shows the first bit to send
    if (!busy && !tick) begin
      dout_d = out_bit(shift_q, ctrl_q.bit_order_select);
    end

    if (wr_data) begin
      if (busy || tick) begin
        write_collision_flag_d = 1'b1;
      end else begin
        shift_d = req_i.wdata;
        dout_d  = out_bit(req_i.wdata, ctrl_q.bit_order_select);
        write_collision_flag_d  = 1'b0;
        if (ctrl_q.port_enable && master) begin
          state_d = XFER_RUN;
          edge_d  = 4'h0;
          div_d   = half_reload(ctrl_q.clock_rate_field);
          phase_d = 1'b0;
        end
      end
    end

    // Read data stand in the cycle after the strobe; unmapped reads give zero
    if (req_i.re) begin
      unique case (req_i.addr)
        `CONTROL_REG_ADDR: begin
          rdata_d = {ctrl_q.port_enable, ctrl_q.controller_select,
                     ctrl_q.clock_idle_level, ctrl_q.sample_edge_select, 1'b0,
                     ctrl_q.bit_order_select, ctrl_q.clock_rate_field};
        end
        `STATUS_REG_ADDR: begin
          rdata_d = {done_q, write_collision_flag_q, 1'b0, ovf_q, full_q, busy, 2'b00};
        end
        `SHIFT_DATA_REG_ADDR: begin
          rdata_d = rx_buf_q;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= ctrl_type'(7'h00);
      state_q    <= XFER_IDLE;
      shift_q    <= `SHIFT_DATA_REG_RST;
      rx_buf_q   <= `SHIFT_DATA_REG_RST;
      rdata_q    <= 8'h00;
      edge_q     <= 4'h0;
      div_q      <= 3'h0;
      phase_q    <= 1'b0;
      dout_q     <= 1'b0;
      sck_prev_q <= 1'b0;
      done_q     <= 1'b0;
      write_collision_flag_q     <= 1'b0;
      ovf_q      <= 1'b0;
      full_q     <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      state_q    <= state_d;
      shift_q    <= shift_d;
      rx_buf_q   <= rx_buf_d;
      rdata_q    <= rdata_d;
      edge_q     <= edge_d;
      div_q      <= div_d;
      phase_q    <= phase_d;
      dout_q     <= dout_d;
      sck_prev_q <= sck_prev_d;
      done_q     <= done_d;
      write_collision_flag_q     <= write_collision_flag_d;
      ovf_q      <= ovf_d;
      full_q     <= full_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  always_comb begin
    rdata_o = rdata_q;
    irq_o = done_q || write_collision_flag_q;
    // master clock rests at idle level
    sck_o.data     = ctrl_q.clock_idle_level ^ phase_q;
    sck_o.drive_n  = !(ctrl_q.port_enable && master);
    mosi_o.data    = dout_q;
    mosi_o.drive_n = !(ctrl_q.port_enable && master);
    miso_o.data    = dout_q;
    miso_o.drive_n = !(ctrl_q.port_enable && !master);
  end

endmodule

`default_nettype wire

// file: sim/spi_port_properties.sv
// Concurrent checks on the serial port's register port and pins
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port_properties
  import spi_port_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire reg_req_type req_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        irq_o,
  input wire pin_out_type sck_o,
  input wire pin_out_type mosi_o,
  input wire pin_out_type miso_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_enable;
    req_i.we && req_i.addr == `CONTROL_REG_ADDR && req_i.wdata[7:6] == 2'b11;
  endsequence
  sequence s_start;
    s_enable ##1 (req_i.we && req_i.addr == `SHIFT_DATA_REG_ADDR);
  endsequence
  property p_reset_quiet;
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> rdata_o == 8'h00 && !irq_o && sck_o.drive_n && mosi_o.drive_n && miso_o.drive_n;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy in reset");
  property p_read_window;
    !req_i.re |=> rdata_o == 8'h00;
  endproperty
  a_read_window: assert property (p_read_window) else $error("read data outside window");
  property p_master_pins;
    !mosi_o.drive_n |-> !sck_o.drive_n && miso_o.drive_n;
  endproperty
  a_master_pins: assert property (p_master_pins) else $error("master pin drive wrong");
  property p_slave_pins;
    !miso_o.drive_n |-> sck_o.drive_n && mosi_o.drive_n;
  endproperty
  a_slave_pins: assert property (p_slave_pins) else $error("slave pin drive wrong");
  property p_idle_level;
    s_enable |-> ##2 (!sck_o.drive_n && sck_o.data == $past(req_i.wdata[5], 2));
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock rest level wrong");
  property p_first_bit;
    s_start |=> !mosi_o.drive_n
      && mosi_o.data == ($past(req_i.wdata[2], 2) ? $past(req_i.wdata[0]) : $past(req_i.wdata[7]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first data bit wrong");
  property p_div16;
    s_start ##0 $past(req_i.wdata[1:0]) == 2'b11
      |=> ##1 $stable(sck_o.data)[*6] ##[1:4] $changed(sck_o.data);
  endproperty
  a_div16: assert property (p_div16) else $error("slowest clock rate wrong");
  property p_collide;
    s_start ##1 (req_i.we && req_i.addr == `SHIFT_DATA_REG_ADDR)
      ##1 (req_i.re && req_i.addr == `STATUS_REG_ADDR) |=> rdata_o[6];
  endproperty
  a_collide: assert property (p_collide) else $error("busy write not flagged");
  property p_read_clears;
    (req_i.re && req_i.addr == `SHIFT_DATA_REG_ADDR)
      ##1 (req_i.re && req_i.addr == `STATUS_REG_ADDR) |=> rdata_o[4:3] == 2'b00;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("data read left full");
  property p_irq_flags;
    req_i.re && req_i.addr == `STATUS_REG_ADDR |=> (rdata_o[7] | rdata_o[6]) == $past(irq_o);
  endproperty
  a_irq_flags: assert property (p_irq_flags) else $error("request line disagrees");
endmodule
bind spi_master_slave_port spi_port_properties checker_inst (.clk_i(clk_i), .rst_i(rst_i),
  .req_i(req_i), .rdata_o(rdata_o), .irq_o(irq_o), .sck_o(sck_o), .mosi_o(mosi_o),
  .miso_o(miso_o));
`default_nettype wire

// file: sim/spi_peer_model.sv
// Far-side serial peer that answers the port as a slave
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic       clk_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       sample_edge_select_i,
  input  wire logic       lsb_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [4:0] edges_q;
  logic [4:0] n;
  logic [2:0] k;
  logic       sck_q;
  // shift on the edge the phase names
  always_comb begin
    n = edges_q + {4'h0, sck_i != sck_q};
    k = sample_edge_select_i ? ((n == 5'h00) ? 3'h0 : 3'((n - 5'h01) >> 1)) : 3'(n >> 1);
    miso_o = tx_i[lsb_i ? k : 3'h7 - k];
    // Line let go after the last bit when sampling on the leading edge: show no held value
    if (n > 5'h0f && !sample_edge_select_i) miso_o = ~tx_i[lsb_i ? 3'h7 : 3'h0];
  end
  always_ff @(posedge clk_i) begin
    sck_q <= sck_i;
    if (load_i) begin
      edges_q <= 5'h00;
    end else if (sck_i != sck_q) begin
      edges_q <= edges_q + 5'h01;
      if (edges_q[0] == sample_edge_select_i) rx_o[lsb_i ? edges_q[3:1] : 3'h7 - edges_q[3:1]] <= mosi_i;
    end
  end
endmodule
`default_nettype wire

// file: sim/spi_master_slave_port_bench.sv
// Self-checking bench for the serial port in master and slave mode
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_cfg.svh"
module spi_master_slave_port_bench;
  import spi_port_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  reg_req_type req_i = '0;
  logic [7:0]  rdata_o, ptx = 8'h00, prx;
  logic        irq_o, sample_edge_select_b = 1'b0, clock_idle_level_b = 1'b0, lsb_b = 1'b0, pload = 1'b0, mosi_b = 1'b0;
  logic        sck_w, mosi_w, miso_w, pmiso;
  pin_out_type sck_o, mosi_o, miso_o;
  int          err_count = 0;
  int          samples_checked = 0;
  always #2.5 clk_i = ~clk_i;
  // Released SCK and MOSI are driven by the bench acting as far master
  assign sck_w  = sck_o.drive_n ? clock_idle_level_b : sck_o.data;
  assign mosi_w = mosi_o.drive_n ? mosi_b : mosi_o.data;
  assign miso_w = miso_o.drive_n ? pmiso : miso_o.data;
  spi_master_slave_port DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .sck_i(sck_w), .sck_o(sck_o), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .miso_i(miso_w), .miso_o(miso_o));
  spi_peer_model peer (.clk_i(clk_i), .load_i(pload), .tx_i(ptx), .sample_edge_select_i(sample_edge_select_b),
    .lsb_i(lsb_b), .sck_i(sck_w), .mosi_i(mosi_w), .miso_o(pmiso), .rx_o(prx));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    req_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    req_i <= '0;
    #1 v = rdata_o;
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(what, exp, v);
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] pd);
    clock_idle_level_b <= c[5];
    sample_edge_select_b <= c[4];
    lsb_b <= c[2];
    ptx <= pd;
    wr(`CONTROL_REG_ADDR, 8'h00);
    req_i <= '0;
    pload <= 1'b1;
    repeat (3) @(posedge clk_i);
    pload <= 1'b0;
    wr(`CONTROL_REG_ADDR, c);
    wr(`SHIFT_DATA_REG_ADDR, d);
  endtask
  task automatic wait_idle();
    logic [7:0] s = 8'hff;
    int n = 0;
    while (s[`STAT_BUSY_BIT] !== 1'b0 && n < 300) begin
      rd(`STATUS_REG_ADDR, s);
      n++;
    end
    if (n >= 300) begin
      check("busy wait", 8'h00, s & 8'h04);
      final_report();
    end
  endtask
  task automatic test_reset();
    rd_chk("control", `CONTROL_REG_ADDR, `CONTROL_REG_RST);
    rd_chk("status", `STATUS_REG_ADDR, 8'h00);
    rd_chk("data", `SHIFT_DATA_REG_ADDR, `SHIFT_DATA_REG_RST);
    wr(8'h00, 8'hff);
    rd_chk("unmapped", 8'h00, 8'h00);
    check("drive", 8'h07, {5'h00, sck_o.drive_n, mosi_o.drive_n, miso_o.drive_n});
    $display("test reset done");
  endtask
  task automatic test_modes();
    logic [7:0] c, v;
    for (int i = 0; i < 4; i++) begin
      c = {2'b11, i[0], i[1], 1'b0, i[0] ^ i[1], i[1:0]};
      v = 8'h96 + i[7:0];
      xfer(c, v, 8'h3c - i[7:0]);
      wait_idle();
      check("peer rx", v, prx);
      rd_chk("status", `STATUS_REG_ADDR, 8'h88);
      check("irq", 8'h01, {7'h00, irq_o});
      rd_chk("rx data", `SHIFT_DATA_REG_ADDR, 8'h3c - i[7:0]);
      rd_chk("status", `STATUS_REG_ADDR, 8'h80);
      check("sck rest", {7'h00, c[5]}, {7'h00, sck_o.data});
      wr(`STATUS_REG_ADDR, 8'h00);
      rd_chk("cleared", `STATUS_REG_ADDR, 8'h00);
    end
    $display("test modes done");
  endtask
  task automatic test_collide();
    xfer(8'hc3, 8'ha5, 8'h5a);
    wr(`SHIFT_DATA_REG_ADDR, 8'h11);
    rd_chk("collision", `STATUS_REG_ADDR, 8'h44);
    wait_idle();
    check("peer rx", 8'ha5, prx);
    xfer(8'hc3, 8'h0f, 8'hf0);
    wait_idle();
    rd_chk("overrun", `STATUS_REG_ADDR, 8'h98);
    rd_chk("rx data", `SHIFT_DATA_REG_ADDR, 8'hf0);
    rd_chk("status", `STATUS_REG_ADDR, 8'h80);
    wr(`CONTROL_REG_ADDR, 8'h00);
    req_i <= '0;
    repeat (3) @(posedge clk_i);
    check("disabled", 8'h03, {6'h00, sck_o.drive_n, mosi_o.drive_n});
    $display("test collide done");
  endtask
  // far master: half period of 8 clocks, sample on leading edge
  task automatic slave_byte(input logic [7:0] d, input logic [7:0] exp);
    logic [7:0] got;
    got = 8'h00;
    for (int b = 7; b >= 0; b--) begin
      mosi_b <= d[b];
      repeat (8) @(posedge clk_i);
      got[b] = miso_w;
      clock_idle_level_b <= 1'b1;
      repeat (8) @(posedge clk_i);
      clock_idle_level_b <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
    check("slave miso", exp, got);
  endtask
  task automatic test_slave();
    wr(`CONTROL_REG_ADDR, 8'h80);
    wr(`SHIFT_DATA_REG_ADDR, 8'hc9);
    req_i <= '0;
    slave_byte(8'h6b, 8'hc9);
    rd_chk("slave status", `STATUS_REG_ADDR, 8'h88);
    slave_byte(8'h24, 8'h6b);
    rd_chk("slave overrun", `STATUS_REG_ADDR, 8'h98);
    rd_chk("slave rx", `SHIFT_DATA_REG_ADDR, 8'h6b);
    $display("test slave done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_modes();
    test_collide();
    test_slave();
    final_report();
  end
endmodule
`default_nettype wire
